//--- verilog/hpsd_pkg.sv
// Constants and carrier types for the host port and strap decoder
package hpsd_pkg;

    // ------------------------------------------------------------------
    // Widths and encodings
    // ------------------------------------------------------------------
    localparam int DATA_W   = 8;
    localparam int ADDR_W   = 8;
    localparam int CHAN_N   = 8;
    localparam int EQC_W    = 5;
    localparam int LOOP_W   = 2;
    localparam int HALF_N   = 4;

    localparam logic [1:0] PTYPE_SEP_STROBE = 2'h0;
    localparam logic [1:0] PTYPE_DIR_STROBE = 2'h1;
    localparam logic [1:0] PTYPE_SYNC_A     = 2'h2;
    localparam logic [1:0] PTYPE_SYNC_B     = 2'h3;

    localparam logic [1:0] LOOP_NONE    = 2'h0;
    localparam logic [1:0] LOOP_ANALOG  = 2'h1;
    localparam logic [1:0] LOOP_REMOTE  = 2'h2;
    localparam logic [1:0] LOOP_DIGITAL = 2'h3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [EQC_W-1:0]  EQC_RST  = 5'h00;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              write_n;
        logic              read_or_data_strobe_n;
        logic              addr_strobe;
        logic              chip_select_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } hpsd_pins_type;

    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } hpsd_req_type;

    typedef logic [CHAN_N-1:0][LOOP_W-1:0] hpsd_loop_type;

endpackage

//--- verilog/hpsd_top.sv
// Host port and hardware-mode strap decoder
`timescale 1ns/100ps
module hpsd_top
    import hpsd_pkg::*;
(
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    // Mode and configuration pins
    input  wire logic                      operating_mode_select_i,
    input  wire logic                      serial_parallel_select_i,
    input  wire logic [1:0]                processor_type_select_i,
    // Bus pins
    input  wire hpsd_pkg::hpsd_pins_type   pins_i,
    input  wire logic                      ready_pin_i,
    output logic                           ready_pin_o,
    output logic                           ready_pin_oe_o,
    output logic [hpsd_pkg::DATA_W-1:0]    data_o,
    output logic                           data_oe_o,
    // Register side
    output hpsd_pkg::hpsd_req_type         req_o,
    input  wire logic [hpsd_pkg::DATA_W-1:0] rdata_i,
    input  wire logic                      serial_rdata_i,
    // Strap outputs
    output logic                           host_mode_o,
    output hpsd_pkg::hpsd_loop_type        loopback_o,
    output logic [hpsd_pkg::EQC_W-1:0]     line_equalizer_code_o
);
    import hpsd_pkg::*;

    // ------------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------------
    // Level of one direction's strobe under the chosen processor type
    function automatic logic strobe_level(
        input logic [1:0] ptype,
        input logic       write_n,
        input logic       ds_n,
        input logic       want_write
    );
        logic dir_ok;
        logic level;
        dir_ok = want_write ? ~write_n : write_n;
        if (ptype == PTYPE_SEP_STROBE) begin
            level = want_write ? ~write_n : ~ds_n;
        end else begin
            // Direction-strobe and sync types share the direction plus strobe decode
            level = ~ds_n & dir_ok;
        end
        return level;
    endfunction

    // One loopback pair taken from an eight-bit strap bus
    function automatic logic [LOOP_W-1:0] lane(
        input logic [DATA_W-1:0] bus,
        input int                pair
    );
        return bus[LOOP_W*pair +: LOOP_W];
    endfunction

    // ------------------------------------------------------------------
    // Mode and strobe decode
    // ------------------------------------------------------------------
    // low selects host
    wire              host_w     = ~operating_mode_select_i;
    wire              sel_w      = host_w & ~pins_i.chip_select_n;
    wire              rd_lvl_w   = strobe_level(processor_type_select_i, pins_i.write_n,
                                                pins_i.read_or_data_strobe_n, 1'b0);
    wire              wr_lvl_w   = strobe_level(processor_type_select_i, pins_i.write_n,
                                                pins_i.read_or_data_strobe_n, 1'b1);
    wire              rd_w       = sel_w & rd_lvl_w;
    wire              wr_w       = sel_w & wr_lvl_w;
    wire              acc_w      = rd_w | wr_w;
    wire              strap_en_w = ~host_w;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [ADDR_W-1:0] addr_q;
    logic              busy_q;
    logic              rdy_q;
    logic              rd_q;
    logic              wr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] dout_q;
    logic              doe_q;
    logic              host_q;
    logic              rpin_q;
    logic              rpin_oe_q;
    hpsd_loop_type     loop_q;
    logic [EQC_W-1:0]  eqc_q;

    // ------------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------------
    // Busy holds until strobe drops so one access gives one request
    wire               start_w   = acc_w & ~busy_q;
    wire  [ADDR_W-1:0] addr_d    = (host_w & pins_i.addr_strobe) ? pins_i.addr : addr_q;
    wire               rd_d      = start_w & rd_w;
    wire               wr_d      = start_w & wr_w;
    wire  [DATA_W-1:0] wdata_d   = start_w ? pins_i.data : wdata_q;
    wire               busy_d    = acc_w;
    wire               rdy_d     = busy_q & acc_w;
    wire               doe_d     = rd_w;
    wire  [DATA_W-1:0] dout_d    = rd_q ? rdata_i : dout_q;
    wire               rpin_d    = serial_parallel_select_i ? serial_rdata_i : rdy_q;
    wire               rpin_oe_d = host_w & (serial_parallel_select_i | sel_w);

    // strap lanes, addr pairs in order to channels 0-3, top data pair to lowest channel of upper half
    hpsd_loop_type loop_dec_w;
    always_comb begin
        loop_dec_w = '0;
        for (int c = 0; c < HALF_N; c++) begin
            loop_dec_w[c]          = lane(pins_i.addr, c);
            loop_dec_w[c + HALF_N] = lane(pins_i.data, HALF_N - 1 - c);
        end
    end

    wire  [EQC_W-1:0] eqc_pins_w = {ready_pin_i, pins_i.chip_select_n, pins_i.addr_strobe,
                                    pins_i.read_or_data_strobe_n, pins_i.write_n};

    wire  hpsd_loop_type    loop_d = strap_en_w ? loop_dec_w : loop_q;
    wire  [EQC_W-1:0]       eqc_d  = strap_en_w ? eqc_pins_w : eqc_q;

    // ------------------------------------------------------------------
    // Host port registers
    // ------------------------------------------------------------------
    // one clock; processor clock taken as clk_i
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_q <= ADDR_RST;
        end else begin
            addr_q <= addr_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            rd_q <= rd_d;
            wr_q <= wr_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdata_q <= DATA_RST;
        end else begin
            wdata_q <= wdata_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
            rdy_q  <= 1'b0;
        end else begin
            busy_q <= busy_d;
            rdy_q  <= rdy_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            doe_q  <= 1'b0;
            dout_q <= DATA_RST;
        end else begin
            doe_q  <= doe_d;
            dout_q <= dout_d;
        end
    end

    // ------------------------------------------------------------------
    // Mode and ready pin registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            host_q <= 1'b0;
        end else begin
            host_q <= host_w;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rpin_q    <= 1'b0;
            rpin_oe_q <= 1'b0;
        end else begin
            rpin_q    <= rpin_d;
            rpin_oe_q <= rpin_oe_d;
        end
    end

    // ------------------------------------------------------------------
    // Strap registers
    // ------------------------------------------------------------------
    // Straps keep their last value in host mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            loop_q <= '0;
        end else begin
            loop_q <= loop_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eqc_q <= EQC_RST;
        end else begin
            eqc_q <= eqc_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign ready_pin_o           = rpin_q;
    assign ready_pin_oe_o        = rpin_oe_q;
    assign data_o                = dout_q;
    assign data_oe_o             = doe_q;
    assign req_o                 = '{rd: rd_q, wr: wr_q, addr: addr_q, wdata: wdata_q};
    assign host_mode_o           = host_q;
    assign loopback_o            = loop_q;
    assign line_equalizer_code_o = eqc_q;

endmodule // hpsd_top

//--- testbench/hpsd_sva.sv
// Checker for the host port and strap decoder
`timescale 1ns/100ps
module hpsd_sva import hpsd_pkg::*; (
    input wire logic clk_i, rst_i, operating_mode_select_i, serial_parallel_select_i, ready_pin_i, data_oe_o,
    input wire logic ready_pin_oe_o, host_mode_o,
    input wire hpsd_pkg::hpsd_pins_type pins_i,
    input wire logic [7:0] rdata_i, data_o,
    input wire hpsd_pkg::hpsd_req_type req_o,
    input wire hpsd_pkg::hpsd_loop_type loopback_o,
    input wire logic [4:0] line_equalizer_code_o
);
    import hpsd_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_MODE: assert property ($fell(operating_mode_select_i) |=> host_mode_o) else $error("no host mode");
    AST_CS: assert property (pins_i.chip_select_n [*2] |-> !req_o.rd && !req_o.wr) else $error("unselected req");
    AST_DIR: assert property (req_o.wr |-> !$past(pins_i.write_n) && !req_o.rd) else $error("bad direction");
    AST_RDATA: assert property (req_o.rd |=> data_oe_o && data_o == $past(rdata_i)) else $error("read data");
    AST_NODRV: assert property (operating_mode_select_i [*3] |-> !data_oe_o) else $error("bus driven");
    AST_SER: assert property ((!operating_mode_select_i && serial_parallel_select_i) [*3] |-> ready_pin_oe_o)
        else $error("serial pin idle");
    AST_EQC: assert property ((!$past(rst_i) && operating_mode_select_i) [*3] |-> line_equalizer_code_o == $past({
        ready_pin_i, pins_i.chip_select_n, pins_i.addr_strobe, pins_i.read_or_data_strobe_n, pins_i.write_n}))
        else $error("eq code");
    AST_LOOP: assert property ((!$past(rst_i) && operating_mode_select_i) [*3] |-> loopback_o[7] ==
        $past(pins_i.data[1:0]) && loopback_o[3] == $past(pins_i.addr[7:6])) else $error("loop strap");
    cover property (req_o.wr);
    cover property (req_o.rd);
    cover property (ready_pin_oe_o && serial_parallel_select_i);
endmodule // hpsd_sva
bind hpsd_top hpsd_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .operating_mode_select_i(operating_mode_select_i),
    .serial_parallel_select_i(serial_parallel_select_i), .ready_pin_i(ready_pin_i), .data_oe_o(data_oe_o),
    .ready_pin_oe_o(ready_pin_oe_o), .host_mode_o(host_mode_o), .pins_i(pins_i), .rdata_i(rdata_i),
    .data_o(data_o), .req_o(req_o), .loopback_o(loopback_o), .line_equalizer_code_o(line_equalizer_code_o));

//--- testbench/hpsd_cpu_model.sv
// Local processor model on the host pins
`timescale 1ns/100ps
module hpsd_cpu_model import hpsd_pkg::*; (
    input  wire logic                    clk_i,
    input  wire logic                    ready_i,
    input  wire logic [7:0]              data_i,
    output hpsd_pkg::hpsd_pins_type      pins_o
);
    logic [7:0] rd_q;
    initial pins_o = {4'b1101, 16'h0};
    task strap(input logic [7:0] a, d, input logic [3:0] e);
        @(posedge clk_i) #5;
        pins_o = {e[0], e[1], e[2], e[3], a, d};
    endtask
    task acc(input logic [1:0] pt, input logic wr, input logic [7:0] a, d, input logic cs);
        @(posedge clk_i) #5;
        pins_o.addr_strobe = 1;
        pins_o.addr = a;
        @(posedge clk_i) #5;
        pins_o.addr_strobe = 0;
        pins_o.chip_select_n = !cs;
        pins_o.data = d;
        pins_o.write_n = !wr;
        pins_o.read_or_data_strobe_n = (pt == 0) ? wr : 1'b0;
        // Bounded wait: a refused access never answers
        for (int i = 0; i < 8 && !ready_i; i++) @(posedge clk_i);
        rd_q = data_i;
        #5;
        pins_o = {4'b1101, a, ~d};
        @(posedge clk_i) #5;
    endtask
endmodule // hpsd_cpu_model

//--- testbench/hpsd_top_tb.sv
// Testbench for the host port and strap decoder
`timescale 1ns/100ps
module hpsd_top_tb;
    import hpsd_pkg::*;
    logic clk_i = 0, rst_i = 1, op = 1, sps = 0, rstrap = 0, srd = 0, rp, rpoe, doe, hm;
    logic [1:0] pt = 0;
    logic [7:0] dout, rdata;
    logic [4:0] line_equalizer_code;
    hpsd_pins_type cpu_pins, pins;
    hpsd_req_type req, last;
    hpsd_loop_type loop;
    int n_errors = 0, checked = 0, n_req = 0;
    always #50 clk_i = ~clk_i;
    assign rdata = req.addr ^ 8'h5a;
    always_comb begin
        pins = cpu_pins;
        if (doe) pins.data = dout;
    end
    always @(posedge clk_i) if (req.rd || req.wr) begin
        last <= req;
        n_req <= n_req + 1;
    end
    hpsd_top u_dut (.clk_i, .rst_i, .operating_mode_select_i(op), .serial_parallel_select_i(sps),
        .processor_type_select_i(pt), .pins_i(pins), .ready_pin_i(rpoe ? rp : rstrap), .ready_pin_o(rp),
        .ready_pin_oe_o(rpoe), .data_o(dout), .data_oe_o(doe), .req_o(req), .rdata_i(rdata),
        .serial_rdata_i(srd), .host_mode_o(hm), .loopback_o(loop), .line_equalizer_code_o(line_equalizer_code));
    hpsd_cpu_model u_cpu (.clk_i, .ready_i(rp && rpoe), .data_i(pins.data), .pins_o(cpu_pins));
    task chk(input logic [7:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task summarize;
        if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task hw(input logic [7:0] a, d, input logic [4:0] e);
        u_cpu.strap(a, d, e[3:0]);
        rstrap = e[4];
        repeat (2) @(posedge clk_i);
        #5;
        for (int c = 0; c < 8; c++) chk(8'(loop[c]), 8'(c < 4 ? a[2*c+:2] : d[14-2*c+:2]));
        chk(8'(line_equalizer_code), 8'(e));
        chk(8'(doe), 8'h0);
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        #5 rst_i = 0;
        hw(8'he4, 8'h1b, 5'h15);
        hw(8'h1b, 8'he4, 5'h0a);
        u_cpu.strap(8'h0, 8'h0, 4'hb);
        op = 0;
        repeat (2) @(posedge clk_i);
        chk(8'(hm), 8'h1);
        for (int p = 0; p < 2; p++) begin
            pt = 2'(p);
            u_cpu.acc(pt, 1, 8'h3c + 8'(p), 8'ha5, 1);
            chk(last.addr, 8'h3c + 8'(p));
            chk(last.wdata, 8'ha5);
            u_cpu.acc(pt, 0, 8'h81 + 8'(p), 8'h00, 1);
            chk(u_cpu.rd_q, (8'h81 + 8'(p)) ^ 8'h5a);
        end
        u_cpu.acc(pt, 1, 8'h10, 8'h77, 0);
        chk(8'(n_req), 8'h4);
        sps = 1;
        srd = 1;
        repeat (3) @(posedge clk_i);
        chk(8'(rpoe), 8'h1);
        chk(8'(rp), 8'h1);
        summarize;
    end
    initial begin
        #100000;
        n_errors++;
        summarize;
    end
endmodule // hpsd_top_tb
